/* File: design/bdd_pkg.sv */
// Package with field positions, encodings, types and timing for the branch and data decoder.
package bdd_pkg;
  // Instruction field positions.
  localparam int COND_MSB = 31;
  localparam int COND_LSB = 28;
  localparam int CLASS_MSB = 27;
  localparam int BR_CLASS_LSB = 25;
  localparam int DP_CLASS_LSB = 26;
  localparam int IMM_BIT = 25;
  localparam int LINK_BIT = 24;
  localparam int OPC_MSB = 24;
  localparam int OPC_LSB = 21;
  localparam int SET_BIT = 20;
  localparam int RN_MSB = 19;
  localparam int RN_LSB = 16;
  localparam int RD_MSB = 15;
  localparam int RD_LSB = 12;
  localparam int ROT_MSB = 11;
  localparam int ROT_LSB = 8;
  localparam int IMM_MSB = 7;
  localparam int SHIFT_MSB = 11;
  localparam int SHIFT_LSB = 4;
  localparam int RM_MSB = 3;
  localparam int OFFS_MSB = 23;
  // Class patterns.
  localparam logic [2:0] BR_CLASS = 3'h5;
  localparam logic [1:0] DP_CLASS = 2'h0;
  // Program counter handling.
  localparam logic [31:0] PREFETCH_BYTES = 32'h8;
  localparam logic [31:0] WORD_BYTES = 32'h4;
  localparam logic [3:0] LINK_REG_IDX = 4'he;
  // Branch timing: one non-sequential cycle plus two sequential ones.
  localparam int BR_N_CYCLES = 1;
  localparam int BR_S_CYCLES = 2;
  // Condition codes.
  localparam logic [3:0] COND_EQ = 4'h0;
  localparam logic [3:0] COND_NE = 4'h1;
  localparam logic [3:0] COND_CS = 4'h2;
  localparam logic [3:0] COND_CC = 4'h3;
  localparam logic [3:0] COND_MI = 4'h4;
  localparam logic [3:0] COND_PL = 4'h5;
  localparam logic [3:0] COND_VS = 4'h6;
  localparam logic [3:0] COND_VC = 4'h7;
  localparam logic [3:0] COND_HI = 4'h8;
  localparam logic [3:0] COND_LS = 4'h9;
  localparam logic [3:0] COND_GE = 4'ha;
  localparam logic [3:0] COND_LT = 4'hb;
  localparam logic [3:0] COND_GT = 4'hc;
  localparam logic [3:0] COND_LE = 4'hd;
  localparam logic [3:0] COND_AL = 4'he;
  // Data-processing opcodes.
  localparam logic [3:0] OP_AND = 4'h0;
  localparam logic [3:0] OP_XOR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_RSUB = 4'h3;
  localparam logic [3:0] OP_ADD = 4'h4;
  localparam logic [3:0] OP_ADDC = 4'h5;
  localparam logic [3:0] OP_SUBB = 4'h6;
  localparam logic [3:0] OP_RSUBB = 4'h7;
  localparam logic [3:0] OP_TSTAND = 4'h8;
  localparam logic [3:0] OP_TSTEQV = 4'h9;
  localparam logic [3:0] OP_CMPSUB = 4'ha;
  localparam logic [3:0] OP_CMPADD = 4'hb;
  localparam logic [3:0] OP_OR = 4'hc;
  localparam logic [3:0] OP_COPY = 4'hd;
  localparam logic [3:0] OP_BCLR = 4'he;
  localparam logic [3:0] OP_COPYN = 4'hf;
  // Reset value of the flags register.
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // Condition flags, negative first.
  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } bdd_flags_t;

  // Branch sequencing phases.
  typedef enum logic [1:0] {
    BDD_IDLE,
    BDD_BR_N,
    BDD_BR_S1,
    BDD_BR_S2
  } bdd_phase_t;

  // Whole state of the decoder.
  typedef struct packed {
    bdd_phase_t phase;
    logic wb_en;
    logic [3:0] wb_idx;
    logic [31:0] wb_data;
    bdd_flags_t flags;
    logic [31:0] target;
  } bdd_core_t;
endpackage

/* File: design/bdd_alu.sv */
// Arithmetic and logic unit for the data-processing class.
`timescale 1ns/1ps
module bdd_alu (
  input wire logic [3:0] opc_i,
  input wire logic [31:0] op1_i,
  input wire logic [31:0] op2_i,
  input wire logic carry_i,
  output logic [31:0] res_o,
  output logic carry_o,
  output logic ovf_o,
  output logic arith_o
);
  logic [31:0] x; // Adder left input.
  logic [31:0] y; // Adder right input, already inverted for subtraction.
  logic ci; // Adder carry in.
  logic [32:0] sum; // Adder sum with carry out.

  // One shared adder; subtraction is x plus not y plus one, so carry means no borrow.
  always_comb begin
    x = op1_i;
    y = op2_i;
    ci = 1'b0;
    arith_o = 1'b1;
    res_o = 32'h0;
    case (opc_i)
      bdd_pkg::OP_SUB, bdd_pkg::OP_CMPSUB: begin
        y = ~op2_i;
        ci = 1'b1;
      end
      bdd_pkg::OP_RSUB: begin
        x = op2_i;
        y = ~op1_i;
        ci = 1'b1;
      end
      bdd_pkg::OP_ADD, bdd_pkg::OP_CMPADD: begin
        ci = 1'b0;
      end
      bdd_pkg::OP_ADDC: begin
        ci = carry_i;
      end
      bdd_pkg::OP_SUBB: begin
        y = ~op2_i;
        ci = carry_i;
      end
      bdd_pkg::OP_RSUBB: begin
        x = op2_i;
        y = ~op1_i;
        ci = carry_i;
      end
      default: begin
        arith_o = 1'b0;
      end
    endcase
    sum = {1'b0, x} + {1'b0, y} + {32'h0, ci};
    case (opc_i)
      bdd_pkg::OP_AND, bdd_pkg::OP_TSTAND: begin
        res_o = op1_i & op2_i;
      end
      bdd_pkg::OP_XOR, bdd_pkg::OP_TSTEQV: begin
        res_o = op1_i ^ op2_i;
      end
      bdd_pkg::OP_OR: begin
        res_o = op1_i | op2_i;
      end
      bdd_pkg::OP_COPY: begin
        res_o = op2_i;
      end
      bdd_pkg::OP_BCLR: begin
        res_o = op1_i & ~op2_i;
      end
      bdd_pkg::OP_COPYN: begin
        res_o = ~op2_i;
      end
      default: begin
        res_o = sum[31:0];
      end
    endcase
    // Carry from bit 31, overflow when like-signed inputs give an unlike sign.
    carry_o = sum[32];
    ovf_o = (x[31] == y[31]) && (sum[31] != x[31]);
  end
endmodule

/* File: design/bdd_decoder.sv */
// Decoder and executor for conditional branches and data-processing instructions.
`timescale 1ns/1ps
// Operation
// - Execute only when condition passes current flags.
// - Branch target adds sign-extended offset times four.
// - Branch arithmetic uses PC eight bytes ahead.
// - Link bit set writes link register.
// - Return address is next instruction's address.
// - Flags not saved; link bits 1:0 cleared.
// - Link bit clear leaves link register alone.
// - Branch takes one N and two S cycles.
// - First operand from 19:16, result to 15:12.
// - Immediate bit selects register or rotated immediate.
// - Immediate: bits 7:0 value, 11:8 rotate.
// - Set bit decides whether flags update.
// - Test and compare ops never write destination.
// - Fifteen conditions decoded; 1111 reserved.
// - Opcodes 0000 to 1111 decoded in order.
// - Arithmetic flags: overflow, carry, zero, negative.
module bdd_decoder (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [31:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic [31:0] pc_i,
  input wire logic [31:0] rn_data_i,
  input wire logic [31:0] shifted_op_i,
  input wire logic shifter_c_i,
  output logic instr_ready_o,
  output logic [3:0] rn_idx_o,
  output logic [3:0] rm_idx_o,
  output logic [7:0] shift_ctl_o,
  output logic wb_en_o,
  output logic [3:0] wb_idx_o,
  output logic [31:0] wb_data_o,
  output bdd_pkg::bdd_flags_t flags_o,
  output logic fetch_flush_o,
  output logic [31:0] fetch_target_o,
  output logic cycle_seq_o
);
  // Condition test against the flags; the reserved code never executes.
  function automatic logic cond_pass(input logic [3:0] cond, input bdd_pkg::bdd_flags_t f);
    case (cond)
      bdd_pkg::COND_EQ: cond_pass = f.z;
      bdd_pkg::COND_NE: cond_pass = !f.z;
      bdd_pkg::COND_CS: cond_pass = f.c;
      bdd_pkg::COND_CC: cond_pass = !f.c;
      bdd_pkg::COND_MI: cond_pass = f.n;
      bdd_pkg::COND_PL: cond_pass = !f.n;
      bdd_pkg::COND_VS: cond_pass = f.v;
      bdd_pkg::COND_VC: cond_pass = !f.v;
      bdd_pkg::COND_HI: cond_pass = f.c && !f.z;
      bdd_pkg::COND_LS: cond_pass = !f.c || f.z;
      bdd_pkg::COND_GE: cond_pass = f.n == f.v;
      bdd_pkg::COND_LT: cond_pass = f.n != f.v;
      bdd_pkg::COND_GT: cond_pass = !f.z && (f.n == f.v);
      bdd_pkg::COND_LE: cond_pass = f.z || (f.n != f.v);
      bdd_pkg::COND_AL: cond_pass = 1'b1;
      default: cond_pass = 1'b0;
    endcase
  endfunction

  // True for the four opcodes that only set flags.
  function automatic logic is_test_op(input logic [3:0] opc);
    is_test_op = (opc[3:2] == bdd_pkg::OP_TSTAND[3:2]);
  endfunction

  bdd_pkg::bdd_core_t cur_q; // Registered state.
  bdd_pkg::bdd_core_t nxt_d; // Next state.
  logic accept; // An instruction is taken this cycle.
  logic is_branch; // Branch class.
  logic is_dp; // Data-processing class.
  logic exec; // Condition passes.
  logic [3:0] opc; // Data-processing opcode.
  logic [31:0] imm_rot; // Rotated immediate operand.
  logic imm_c; // Carry out of the immediate rotate.
  logic [4:0] rot_amt; // Rotate amount, twice the field.
  logic [63:0] imm_dbl; // Immediate doubled for rotation.
  logic [31:0] op2; // Selected second operand.
  logic op2_c; // Carry that logical operations pass to the flags.
  logic [31:0] alu_res; // Operation result.
  logic alu_c; // Adder carry out.
  logic alu_v; // Adder overflow.
  logic alu_arith; // Opcode is arithmetic.
  logic [31:0] br_offs; // Sign-extended word offset.

  assign accept = instr_valid_i && instr_ready_o;
  // Class decode; a branch needs 101, data processing needs 00 in the top pair.
  assign is_branch = (instr_i[bdd_pkg::CLASS_MSB:bdd_pkg::BR_CLASS_LSB] == bdd_pkg::BR_CLASS);
  assign is_dp = (instr_i[bdd_pkg::CLASS_MSB:bdd_pkg::DP_CLASS_LSB] == bdd_pkg::DP_CLASS);
  assign exec = cond_pass(instr_i[bdd_pkg::COND_MSB:bdd_pkg::COND_LSB], cur_q.flags);
  assign opc = instr_i[bdd_pkg::OPC_MSB:bdd_pkg::OPC_LSB];
  // Register indices go straight to the register file and shifter.
  assign rn_idx_o = instr_i[bdd_pkg::RN_MSB:bdd_pkg::RN_LSB];
  assign rm_idx_o = instr_i[bdd_pkg::RM_MSB:0];
  assign shift_ctl_o = instr_i[bdd_pkg::SHIFT_MSB:bdd_pkg::SHIFT_LSB];
  // Rotating the zero-extended byte right by twice the field.
  assign rot_amt = {instr_i[bdd_pkg::ROT_MSB:bdd_pkg::ROT_LSB], 1'b0};
  assign imm_dbl = {2{24'h0, instr_i[bdd_pkg::IMM_MSB:0]}};
  assign imm_rot = imm_dbl[rot_amt +: 32];
  // A zero rotate leaves carry alone, otherwise carry takes bit 31.
  assign imm_c = (rot_amt == 5'h0) ? cur_q.flags.c : imm_rot[31];
  assign op2 = instr_i[bdd_pkg::IMM_BIT] ? imm_rot : shifted_op_i;
  assign op2_c = instr_i[bdd_pkg::IMM_BIT] ? imm_c : shifter_c_i;
  assign br_offs = {{6{instr_i[bdd_pkg::OFFS_MSB]}}, instr_i[bdd_pkg::OFFS_MSB:0], 2'b00};

  bdd_alu u_alu (
    .opc_i(opc),
    .op1_i(rn_data_i),
    .op2_i(op2),
    .carry_i(cur_q.flags.c),
    .res_o(alu_res),
    .carry_o(alu_c),
    .ovf_o(alu_v),
    .arith_o(alu_arith)
  );

  // Next-state logic: one instruction at a time, branches hold off the next for three cycles.
  always_comb begin
    nxt_d = cur_q;
    nxt_d.wb_en = 1'b0;
    case (cur_q.phase)
      bdd_pkg::BDD_IDLE: begin
        if (accept && exec && is_branch) begin
          // pc_i already runs eight bytes ahead, so the target is a plain sum.
          nxt_d.target = pc_i + br_offs;
          nxt_d.phase = bdd_pkg::BDD_BR_N;
          // A plain branch skips this, so the link register keeps its value.
          if (instr_i[bdd_pkg::LINK_BIT]) begin
            // One word back from the prefetch PC is the next instruction; flags stay out.
            nxt_d.wb_en = 1'b1;
            nxt_d.wb_idx = bdd_pkg::LINK_REG_IDX;
            nxt_d.wb_data = {pc_i[31:2] - bdd_pkg::WORD_BYTES[31:2], 2'b00};
          end
        end else if (accept && exec && is_dp) begin
          // Compare forms never write, even though they share the adder.
          if (!is_test_op(opc)) begin
            nxt_d.wb_en = 1'b1;
            nxt_d.wb_idx = instr_i[bdd_pkg::RD_MSB:bdd_pkg::RD_LSB];
            nxt_d.wb_data = alu_res;
          end
          if (instr_i[bdd_pkg::SET_BIT]) begin
            nxt_d.flags.n = alu_res[31];
            nxt_d.flags.z = (alu_res == 32'h0);
            nxt_d.flags.c = alu_arith ? alu_c : op2_c;
            nxt_d.flags.v = alu_arith ? alu_v : cur_q.flags.v;
          end
        end
      end
      // Non-sequential fetch from the target, then two sequential cycles.
      bdd_pkg::BDD_BR_N: nxt_d.phase = bdd_pkg::BDD_BR_S1;
      bdd_pkg::BDD_BR_S1: nxt_d.phase = bdd_pkg::BDD_BR_S2;
      default: nxt_d.phase = bdd_pkg::BDD_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_q <= '{phase: bdd_pkg::BDD_IDLE, wb_en: 1'b0, wb_idx: 4'h0, wb_data: 32'h0,
                 flags: bdd_pkg::FLAGS_RST, target: 32'h0};
    end else begin
      cur_q <= nxt_d;
    end
  end

  // Handshake outputs come straight from the phase; data from flops.
  assign instr_ready_o = (cur_q.phase == bdd_pkg::BDD_IDLE);
  assign fetch_flush_o = (cur_q.phase == bdd_pkg::BDD_BR_N);
  assign cycle_seq_o = (cur_q.phase != bdd_pkg::BDD_BR_N);
  assign fetch_target_o = cur_q.target;
  assign wb_en_o = cur_q.wb_en;
  assign wb_idx_o = cur_q.wb_idx;
  assign wb_data_o = cur_q.wb_data;
  assign flags_o = cur_q.flags;

  chk_cond_fail_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    accept && !exec |=> !wb_en_o && !fetch_flush_o && $stable(flags_o))
    else $error("failed condition still had an effect");
  chk_branch_target: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    accept && exec && is_branch |=> fetch_flush_o
      && fetch_target_o == $past(pc_i) + $past(br_offs))
    else $error("branch target wrong");
  chk_link_value: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    accept && exec && is_branch && instr_i[bdd_pkg::LINK_BIT] |=> wb_en_o
      && wb_idx_o == bdd_pkg::LINK_REG_IDX && wb_data_o[1:0] == 2'b00
      && wb_data_o[31:2] == $past(pc_i[31:2]) - 30'h1)
    else $error("return address wrong");
  chk_no_link: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    accept && is_branch && !instr_i[bdd_pkg::LINK_BIT] |=> !wb_en_o)
    else $error("plain branch wrote a register");
  chk_branch_cycles: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(fetch_flush_o) |-> !cycle_seq_o ##1 (cycle_seq_o && !instr_ready_o)[*2] ##1 instr_ready_o)
    else $error("branch did not take three cycles");
  chk_dest_index: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    accept && exec && is_dp && !is_test_op(opc) |=> wb_en_o
      && wb_idx_o == $past(instr_i[bdd_pkg::RD_MSB:bdd_pkg::RD_LSB]))
    else $error("destination index wrong");
  chk_test_nowrite: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    accept && is_dp && is_test_op(opc) |=> !wb_en_o)
    else $error("test opcode wrote a register");
  chk_flags_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    accept && !(is_dp && instr_i[bdd_pkg::SET_BIT]) |=> $stable(flags_o))
    else $error("flags changed without set bit");
  chk_zero_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    accept && exec && is_dp && instr_i[bdd_pkg::SET_BIT] |=> flags_o.z == ($past(alu_res) == 32'h0)
      && flags_o.n == $past(alu_res[31]))
    else $error("zero or negative flag wrong");
  // The flush is one pulse, so the fetch stage restarts exactly once per taken branch.
  chk_flush_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    fetch_flush_o |=> !fetch_flush_o)
    else $error("flush held longer than one cycle");
  // The reserved condition code must behave like a failed condition.
  chk_reserved_cond: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    accept && (&instr_i[bdd_pkg::COND_MSB:bdd_pkg::COND_LSB]) |=> !wb_en_o && !fetch_flush_o)
    else $error("reserved condition had an effect");
  // The target output only moves when a branch is actually taken.
  chk_target_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !(accept && exec && is_branch) |=> $stable(fetch_target_o))
    else $error("branch target moved without a taken branch");
  // Logical operations leave overflow alone even when they update the other flags.
  chk_logic_ovf: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    accept && exec && is_dp && instr_i[bdd_pkg::SET_BIT] && !alu_arith
      |=> flags_o.v == $past(flags_o.v))
    else $error("logical operation changed the overflow flag");
endmodule

/* File: bench/bdd_regfile_model.sv */
// Register file and shifter model that sits on the far side of the decoder.
`timescale 1ns/1ps
module bdd_regfile_model (
  input wire logic sys_clk_i,
  input wire logic [3:0] rn_idx_i,
  input wire logic [3:0] rm_idx_i,
  input wire logic wb_en_i,
  input wire logic [3:0] wb_idx_i,
  input wire logic [31:0] wb_data_i,
  input wire bdd_pkg::bdd_flags_t flags_i,
  output logic [31:0] rn_data_o,
  output logic [31:0] shifted_op_o,
  output logic shifter_c_o
);
  // Sixteen registers; the bench preloads them, so a plain always is used here.
  logic [31:0] regs [16];
  // A write lands at the edge that ends the write strobe.
  always @(posedge sys_clk_i) begin
    if (wb_en_i) begin
      regs[wb_idx_i] <= wb_data_i;
    end
  end
  // Reads bypass a pending write, so a dependent op issued back to back sees it.
  always_comb begin
    rn_data_o = (wb_en_i && wb_idx_i == rn_idx_i) ? wb_data_i : regs[rn_idx_i];
    shifted_op_o = (wb_en_i && wb_idx_i == rm_idx_i) ? wb_data_i : regs[rm_idx_i];
    // Only a zero shift is modelled; its carry out is the old carry flag.
    shifter_c_o = flags_i.c;
  end
endmodule

/* File: bench/branch_dataproc_decoder_tb_top.sv */
// Self-checking bench for the branch and data-processing decoder.
`timescale 1ns/1ps
module branch_dataproc_decoder_tb_top;
  logic sys_clk_i, rst_i, instr_valid_i, shifter_c_i, instr_ready_o, wb_en_o;
  logic fetch_flush_o, cycle_seq_o;
  logic [31:0] instr_i, pc_i, rn_data_i, shifted_op_i, wb_data_o, fetch_target_o;
  logic [3:0] rn_idx_o, rm_idx_o, wb_idx_o;
  logic [7:0] shift_ctl_o;
  bdd_pkg::bdd_flags_t flags_o;
  // Expected register contents and flags, kept from the bench's own reckoning.
  logic [31:0] mirror [16];
  bdd_pkg::bdd_flags_t eflags;
  int fail_count, checks, cyc;

  bdd_decoder dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .pc_i(pc_i), .rn_data_i(rn_data_i),
    .shifted_op_i(shifted_op_i), .shifter_c_i(shifter_c_i), .instr_ready_o(instr_ready_o),
    .rn_idx_o(rn_idx_o), .rm_idx_o(rm_idx_o), .shift_ctl_o(shift_ctl_o), .wb_en_o(wb_en_o),
    .wb_idx_o(wb_idx_o), .wb_data_o(wb_data_o), .flags_o(flags_o),
    .fetch_flush_o(fetch_flush_o), .fetch_target_o(fetch_target_o),
    .cycle_seq_o(cycle_seq_o));

  bdd_regfile_model pm_u (.sys_clk_i(sys_clk_i), .rn_idx_i(rn_idx_o), .rm_idx_i(rm_idx_o),
    .wb_en_i(wb_en_o), .wb_idx_i(wb_idx_o), .wb_data_i(wb_data_o), .flags_i(flags_o),
    .rn_data_o(rn_data_i), .shifted_op_o(shifted_op_i), .shifter_c_o(shifter_c_i));

  // The clock runs at 50 MHz.
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // Condition codes come in pairs; the odd one of each pair is the inverse.
  function automatic logic cond_ok(input logic [3:0] cd, input bdd_pkg::bdd_flags_t f);
    logic t;
    case (cd[3:1])
      3'h0: t = f.z;
      3'h1: t = f.c;
      3'h2: t = f.n;
      3'h3: t = f.v;
      3'h4: t = f.c && !f.z;
      3'h5: t = f.n == f.v;
      3'h6: t = !f.z && f.n == f.v;
      default: return cd == 4'he;
    endcase
    return t ^ cd[0];
  endfunction

  // Reference operation; returns carry, overflow and result, in that order.
  function automatic logic [33:0] alu(input logic [3:0] op, input logic [31:0] a,
    input logic [31:0] b, input logic ci, input logic bc, input logic v0);
    logic [31:0] x;
    logic [31:0] y;
    logic [32:0] s;
    logic sb;
    sb = op inside {4'h2, 4'h3, 4'h6, 4'h7, 4'ha};
    x = (op == 4'h3 || op == 4'h7) ? b : a;
    y = (op == 4'h3 || op == 4'h7) ? a : b;
    y = sb ? ~y : y;
    s = {1'b0, x} + {1'b0, y} + 33'(op inside {4'h5, 4'h6, 4'h7} ? ci : sb);
    case (op)
      4'h0, 4'h8: return {bc, v0, a & b};
      4'h1, 4'h9: return {bc, v0, a ^ b};
      4'hc: return {bc, v0, a | b};
      4'hd: return {bc, v0, b};
      4'he: return {bc, v0, a & ~b};
      4'hf: return {bc, v0, ~b};
      default: return {s[32], x[31] == y[31] && s[31] != x[31], s[31:0]};
    endcase
  endfunction

  // One comparison; case inequality so that an unknown never passes.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  // One data-processing op, entered and left at a falling edge.
  task automatic dp_test(input int i);
    logic [3:0] cd, op, rn, rd;
    logic [11:0] o2;
    logic [63:0] dbl;
    logic [31:0] b;
    logic [33:0] r;
    logic im, s, ok, wr, bc;
    cd = 4'(i);
    op = 4'($urandom);
    im = 1'($urandom);
    s = op[3:2] == 2'h2 ? 1'b1 : 1'($urandom);
    rn = 4'($urandom);
    rd = 4'($urandom);
    // The shift field stays zero in register form, since the model only passes Rm through.
    o2 = im ? 12'($urandom) : {8'h0, 4'($urandom)};
    instr_i = {cd, 2'h0, im, op, s, rn, rd, o2};
    dbl = {2{24'h0, o2[7:0]}} >> (2 * o2[11:8]);
    b = im ? dbl[31:0] : mirror[o2[3:0]];
    bc = (im && o2[11:8] != 4'h0) ? b[31] : eflags.c;
    r = alu(op, mirror[rn], b, eflags.c, bc, eflags.v);
    ok = cond_ok(cd, eflags);
    wr = ok && op[3:2] != 2'h2;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    if (ok && s) begin
      eflags = {r[31], r[31:0] == 32'h0, r[33], r[32]};
    end
    if (wr) begin
      mirror[rd] = r[31:0];
      chk("wb_idx", 32'(rd), 32'(wb_idx_o));
      chk("wb_data", r[31:0], wb_data_o);
    end
    chk("wb_en", 32'(wr), 32'(wb_en_o));
    chk("flags", 32'(eflags), 32'(flags_o));
    chk("fields", 32'({rn, o2}), 32'({rn_idx_o, shift_ctl_o, rm_idx_o}));
  endtask

  // One branch; a taken one is followed by a probe op that must be refused.
  task automatic br(input logic [3:0] cd, input logic lk, input logic [23:0] off);
    logic [31:0] pc;
    logic ok;
    pc = $urandom & 32'hffff_fffc;
    pc_i = pc;
    instr_i = {cd, 3'h5, lk, off};
    ok = cond_ok(cd, eflags);
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk("flush", 32'(ok), 32'(fetch_flush_o));
    chk("wb_en", 32'(ok && lk), 32'(wb_en_o));
    chk("seq", 32'(!ok), 32'(cycle_seq_o));
    chk("ready", 32'(!ok), 32'(instr_ready_o));
    chk("flags", 32'(eflags), 32'(flags_o));
    if (ok) begin
      chk("target", pc + {{6{off[23]}}, off, 2'h0}, fetch_target_o);
      if (lk) begin
        mirror[14] = (pc - 32'h4) & 32'hffff_fffc;
        chk("wb_idx", 32'he, 32'(wb_idx_o));
        chk("link", mirror[14], wb_data_o);
      end
      // A copy into register one stands waiting while the decoder is busy.
      instr_i = 32'he1a0_1000;
      // The N cycle and the two S cycles pass before the decoder takes anything again.
      for (int k = 0; k < bdd_pkg::BR_N_CYCLES + bdd_pkg::BR_S_CYCLES; k++) begin
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        chk("refused", 32'h0, 32'(wb_en_o | fetch_flush_o));
        chk("ready", 32'(k == bdd_pkg::BR_S_CYCLES), 32'(instr_ready_o));
      end
    end
  endtask

  // Ends the run; called at the end and by the hang limit.
  task automatic close_out();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The whole run needs under a thousand cycles, so this limit only trips on a hang.
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      close_out();
    end
  end

  // Main sequence: reset, a run of data ops, then branches mixed among them.
  initial begin
    void'($urandom(32'hf85a));
    rst_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = 32'h0;
    pc_i = 32'h0;
    eflags = bdd_pkg::FLAGS_RST;
    for (int i = 0; i < 16; i++) begin
      mirror[i] = $urandom;
      pm_u.regs[i] = mirror[i];
    end
    repeat (6) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    instr_valid_i = 1'b1;
    for (int i = 0; i < 256; i++) begin
      dp_test(i);
    end
    $display("test data_ops done");
    // Every code with and without link; the first offsets are the extreme values.
    for (int j = 0; j < 32; j++) begin
      br(4'(j), j[4], j < 2 ? {j[0], {23{~j[0]}}} : 24'($urandom));
      repeat (3) dp_test($urandom);
    end
    $display("test branches done");
    close_out();
  end
endmodule
